// ---- cbs_addr_gen.sv ----
`timescale 1ns/1ps
`include "cbs_defines.svh"

module cbs_addr_gen
    import cbs_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    cbs_cyc_if.agen   cyc
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] opr;
        logic        vlo;
    } cbs_agen_t;

    cbs_agen_t s_q;
    cbs_agen_t s_d;

    // Address and direction for the symbol about to be issued
    always_comb begin
        s_d     = s_q;
        cyc.rw  = ~cbs_is_write(cyc.sym);
        cyc.addr = s_q.pc;
        case (cyc.sym)
            CBS_FETCH: cyc.addr = s_q.pc;                           // RQ3
            CBS_RD:    cyc.addr = s_q.opr;                          // RQ4
            CBS_WR:    cyc.addr = s_q.opr;                          // RQ5
            CBS_PUSH:  cyc.addr = s_q.sp;                           // RQ6
            CBS_POP:   cyc.addr = s_q.sp + `CBS_ONE16;              // RQ7
            CBS_VEC:   cyc.addr = {`CBS_VEC_PAGE, cyc.vec_base[7:1], s_q.vlo}; // RQ8
            default:   cyc.addr = s_q.pc;  // Free cycle, bus not needed
        endcase
        if (cyc.opr_load) begin
            s_d.opr = cyc.opr_addr;
            s_d.vlo = 1'b0;
        end else if (cyc.go) begin
            case (cyc.sym)
                CBS_FETCH: s_d.pc  = s_q.pc + `CBS_ONE16;           // RQ3
                CBS_RD,
                CBS_WR:    s_d.opr = s_q.opr + `CBS_ONE16;
                CBS_PUSH:  s_d.sp  = s_q.sp - `CBS_ONE16;           // RQ6
                CBS_POP:   s_d.sp  = s_q.sp + `CBS_ONE16;           // RQ7
                CBS_VEC:   s_d.vlo = 1'b1;                          // RQ8
                default:   s_d.opr = s_q.opr;
            endcase
        end
        // Vector bytes land in PC a cycle later; they win over fetch advance
        if (cyc.vec_hi_ld) begin
            s_d.pc[15:8] = cyc.vec_data;                            // RQ8
        end
        if (cyc.vec_lo_ld) begin
            s_d.pc[7:0] = cyc.vec_data;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{pc: `CBS_PC_RESET, sp: `CBS_SP_RESET, opr: 16'h0000, vlo: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

endmodule // cbs_addr_gen

// ---- cbs_cyc_if.sv ----
`timescale 1ns/1ps

interface cbs_cyc_if;
    import cbs_pkg::*;

    cbs_sym_t    sym;
    logic        go;
    logic        opr_load;
    logic [15:0] opr_addr;
    logic [7:0]  vec_base;
    logic        vec_hi_ld;
    logic        vec_lo_ld;
    logic [7:0]  vec_data;
    logic [15:0] addr;
    logic        rw;

    modport seq  (output sym, go, opr_load, opr_addr, vec_base, vec_hi_ld, vec_lo_ld,
                  vec_data, input addr, rw);
    modport agen (input sym, go, opr_load, opr_addr, vec_base, vec_hi_ld, vec_lo_ld,
                  vec_data, output addr, rw);
endinterface

// ---- cbs_defines.svh ----
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH

// ----------------------------------------------------------------
// Cycle symbol encodings
// ----------------------------------------------------------------
`define CBS_SYM_W        3
`define CBS_SYM_FREE     3'h0
`define CBS_SYM_FETCH    3'h1
`define CBS_SYM_RD       3'h2
`define CBS_SYM_WR       3'h3
`define CBS_SYM_PUSH     3'h4
`define CBS_SYM_POP      3'h5
`define CBS_SYM_VEC      3'h6

// ----------------------------------------------------------------
// Reset values and address layout
// ----------------------------------------------------------------
`define CBS_MAX_LEN      11
`define CBS_PC_RESET     16'h0000
`define CBS_SP_RESET     16'h00ff
`define CBS_VEC_PAGE     8'hff
`define CBS_ONE16        16'h0001

`endif

// ---- cbs_mem_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Memory and stack on the far side of the system bus
// ----------------------------------------------------------------
module cbs_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_valid,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_rw,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [0:65535];

    // Unwritten bytes follow an address pattern so a wrong address shows up
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'ha5;
        end
    end

    // Plain array read, so a pop right after a push at one address sees the new byte
    assign o_rdata = mem[i_addr];

    // Store on the edge that ends a write cycle; contents survive a reset
    always @(posedge i_clk_sys) begin
        if (i_valid === 1'b1 && i_rw === 1'b0) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule // cbs_mem_model

// ---- cbs_pkg.sv ----
`include "cbs_defines.svh"

package cbs_pkg;

    // Bus cycle kinds, one per code letter
    typedef enum logic [2:0] {
        CBS_FREE  = `CBS_SYM_FREE,
        CBS_FETCH = `CBS_SYM_FETCH,
        CBS_RD    = `CBS_SYM_RD,
        CBS_WR    = `CBS_SYM_WR,
        CBS_PUSH  = `CBS_SYM_PUSH,
        CBS_POP   = `CBS_SYM_POP,
        CBS_VEC   = `CBS_SYM_VEC
    } cbs_sym_t;

    // Sequencer states
    typedef enum logic [1:0] {
        CBS_ST_IDLE = 2'h0,
        CBS_ST_RUN  = 2'h1,
        CBS_ST_HALT = 2'h2
    } cbs_state_t;

    // Writes only for operand store and push
    function automatic logic cbs_is_write(input cbs_sym_t sym);
        return (sym == CBS_WR) || (sym == CBS_PUSH);
    endfunction

    // Cycles that return a byte to the core
    function automatic logic cbs_is_read_data(input cbs_sym_t sym);
        return (sym == CBS_RD) || (sym == CBS_POP) || (sym == CBS_VEC);
    endfunction

endpackage

// ---- cbs_sequencer.sv ----
`timescale 1ns/1ps
`include "cbs_defines.svh"

// Functional notes
// [RQ1] Free cycle needs no bus and lasts exactly one clock.
// [RQ2] Free cycles are always presented as reads.
// [RQ3] Fetch reads the next sequential program address after the previous fetch.
// [RQ4] Operand read moves one byte from memory into the core.
// [RQ5] Operand write moves one byte from the core to memory.
// [RQ6] Push writes one byte at the stack pointer.
// [RQ7] Pop reads one byte from the stack area.
// [RQ8] Vector reads from the top page, high byte before low byte.
// [RQ9] Wait clears the interrupt mask, then halts until an interrupt.
// [RQ10] One typed bus cycle per clock, in code-string order.
module cbs_sequencer
    import cbs_pkg::*;
#(
    parameter int MAX_LEN = `CBS_MAX_LEN
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst,
    input  wire logic                          i_start,
    input  wire logic [MAX_LEN-1:0][2:0]       i_code,
    input  wire logic [$clog2(MAX_LEN+1)-1:0]  i_len,
    input  wire logic                          i_is_wait,
    input  wire logic [15:0]                   i_opr_addr,
    input  wire logic [7:0]                    i_wdata,
    input  wire logic [7:0]                    i_vec_base,
    input  wire logic                          i_irq,
    input  wire logic [7:0]                    i_bus_rdata,
    output logic                               o_ready,
    output logic                               o_valid,
    output logic [2:0]                         o_cyc_type,
    output logic [15:0]                        o_addr,
    output logic                               o_rw,
    output logic [7:0]                         o_wdata,
    output logic [7:0]                         o_rdata,
    output logic                               o_rdata_valid,
    output logic                               o_done,
    output logic                               o_halted,
    output logic                               o_imask
);

    localparam int LW = $clog2(MAX_LEN+1);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (MAX_LEN < 2 || MAX_LEN > 16) begin : g_bad_len
        $error("cbs_sequencer: MAX_LEN must be 2..16");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        cbs_state_t                st;
        logic [MAX_LEN-1:0][2:0]   code;
        logic [LW-1:0]             len;
        logic [LW-1:0]             idx;
        logic                      is_wait;
        logic [7:0]                wdata;
        logic                      ready;
        logic                      valid;
        cbs_sym_t                  typ;
        logic [15:0]               addr;
        logic                      rw;
        logic [7:0]                bus_wdata;
        logic [7:0]                rdata;
        logic                      rdata_valid;
        logic                      vphase;
        logic                      done;
        logic                      imask;
        logic                      halted;
    } cbs_seq_t;

    cbs_seq_t  s_q;
    cbs_seq_t  s_d;
    cbs_cyc_if cyc ();
    cbs_sym_t  sym_now;

    cbs_addr_gen u_agen (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .cyc       (cyc)
    );

    // ----------------------------------------------------------------
    // Next-cycle selection
    // ----------------------------------------------------------------
    // Idle and halt still issue a free cycle so the bus sees one cycle per clock
    always_comb begin
        s_d          = s_q;
        sym_now      = CBS_FREE;                                    // RQ1
        s_d.done     = 1'b0;
        cyc.opr_load = 1'b0;
        cyc.opr_addr = i_opr_addr;
        cyc.vec_base = i_vec_base;
        case (s_q.st)
            CBS_ST_IDLE: begin
                if (i_start && i_len != '0) begin
                    s_d.st       = CBS_ST_RUN;
                    s_d.code     = i_code;
                    s_d.len      = i_len;
                    s_d.idx      = '0;
                    s_d.is_wait  = i_is_wait;
                    s_d.wdata    = i_wdata;
                    s_d.ready    = 1'b0;
                    cyc.opr_load = 1'b1;
                end
            end
            CBS_ST_RUN: begin
                sym_now = cbs_sym_t'(s_q.code[s_q.idx]);            // RQ10
                s_d.idx = s_q.idx + LW'(1);
                if (s_q.idx == s_q.len - LW'(1)) begin
                    if (s_q.is_wait) begin
                        s_d.st    = CBS_ST_HALT;
                        s_d.imask = 1'b0;                           // RQ9
                    end else begin
                        s_d.st    = CBS_ST_IDLE;
                        s_d.ready = 1'b1;
                        s_d.done  = 1'b1;
                    end
                end
            end
            CBS_ST_HALT: begin
                // Core stopped: only free cycles until an interrupt wakes it
                if (i_irq) begin                                    // RQ9
                    s_d.st    = CBS_ST_IDLE;
                    s_d.ready = 1'b1;
                    s_d.done  = 1'b1;
                end
            end
            default: begin
                s_d.st    = CBS_ST_IDLE;
                s_d.ready = 1'b1;
            end
        endcase
        cyc.sym = sym_now;
        cyc.go  = (s_q.st == CBS_ST_RUN);
        // Register the presented cycle; every clock carries one
        s_d.valid     = 1'b1;                                       // RQ10
        s_d.typ       = sym_now;
        s_d.addr      = cyc.addr;
        s_d.rw        = cyc.rw;                                     // RQ2
        s_d.bus_wdata = cbs_is_write(sym_now) ? s_q.wdata : 8'h00;  // RQ5
        // Capture returned byte at the end of the presented cycle
        s_d.rdata_valid = cbs_is_read_data(s_q.typ);                // RQ4
        if (cbs_is_read_data(s_q.typ)) begin
            s_d.rdata = i_bus_rdata;
        end
        // Vector bytes alternate high then low
        cyc.vec_hi_ld = (s_q.typ == CBS_VEC) && !s_q.vphase;        // RQ8
        cyc.vec_lo_ld = (s_q.typ == CBS_VEC) && s_q.vphase;
        cyc.vec_data  = i_bus_rdata;
        if (s_q.typ == CBS_VEC) begin
            s_d.vphase = ~s_q.vphase;
        end
        if (cyc.opr_load) begin
            s_d.vphase = 1'b0;
        end
        // Halt flag kept in a flop so the output needs no decode
        s_d.halted = (s_d.st == CBS_ST_HALT);                       // RQ9
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q       <= '0;
            s_q.st    <= CBS_ST_IDLE;
            s_q.ready <= 1'b1;
            s_q.rw    <= 1'b1;
            s_q.imask <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs straight from flops
    // ----------------------------------------------------------------
    assign o_ready       = s_q.ready;
    assign o_valid       = s_q.valid;
    assign o_cyc_type    = s_q.typ;
    assign o_addr        = s_q.addr;
    assign o_rw          = s_q.rw;
    assign o_wdata       = s_q.bus_wdata;
    assign o_rdata       = s_q.rdata;
    assign o_rdata_valid = s_q.rdata_valid;
    assign o_done        = s_q.done;
    assign o_halted      = s_q.halted;
    assign o_imask       = s_q.imask;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_free_one_clk;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.valid && s_q.typ == CBS_FREE |=> s_q.valid;
    endproperty
    a_free_one_clk: assert property (p_free_one_clk) // RQ1
        else $error("free cycle not followed by a new cycle");

    property p_free_read;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.valid && s_q.typ == CBS_FREE |-> s_q.rw && s_q.bus_wdata == 8'h00;
    endproperty
    a_free_read: assert property (p_free_read) // RQ2
        else $error("free cycle presented as write");

    property p_fetch_seq;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.typ == CBS_FETCH ##1 s_q.typ == CBS_FETCH |->
            s_q.addr == $past(s_q.addr) + `CBS_ONE16;
    endproperty
    a_fetch_seq: assert property (p_fetch_seq) // RQ3
        else $error("back to back fetches not sequential");

    property p_rd_capture;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.typ == CBS_RD |=> s_q.rdata_valid && s_q.rdata == $past(i_bus_rdata);
    endproperty
    a_rd_capture: assert property (p_rd_capture) // RQ4
        else $error("operand read byte not captured");

    property p_wr_data;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.typ == CBS_WR |-> !s_q.rw && s_q.bus_wdata == s_q.wdata;
    endproperty
    a_wr_data: assert property (p_wr_data) // RQ5
        else $error("operand write wrong direction or data");

    property p_push_dec;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.typ == CBS_PUSH ##1 s_q.typ == CBS_PUSH |->
            !s_q.rw && s_q.addr == $past(s_q.addr) - `CBS_ONE16;
    endproperty
    a_push_dec: assert property (p_push_dec) // RQ6
        else $error("push not a write below previous push");

    property p_pop_inc;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.typ == CBS_POP ##1 s_q.typ == CBS_POP |->
            s_q.rw && s_q.addr == $past(s_q.addr) + `CBS_ONE16;
    endproperty
    a_pop_inc: assert property (p_pop_inc) // RQ7
        else $error("pop not a read above previous pop");

    sequence s_vec_pair;
        s_q.typ == CBS_VEC && !s_q.vphase ##1 s_q.typ == CBS_VEC;
    endsequence
    property p_vec_order;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_vec_pair |-> s_q.addr[15:8] == `CBS_VEC_PAGE && s_q.addr[0] &&
            !$past(s_q.addr[0]) && s_q.rw;
    endproperty
    a_vec_order: assert property (p_vec_order) // RQ8
        else $error("vector bytes out of order or off top page");

    sequence s_wait_end;
        s_q.st == CBS_ST_RUN && s_q.is_wait && s_q.idx == s_q.len - LW'(1);
    endsequence
    property p_wait_halt;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wait_end |=> o_halted && !s_q.imask ##1 s_q.typ == CBS_FREE;
    endproperty
    a_wait_halt: assert property (p_wait_halt) // RQ9
        else $error("wait did not halt with mask cleared");

    property p_code_order;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_q.st == CBS_ST_RUN |=> s_q.valid && s_q.typ == $past(s_q.code[s_q.idx]);
    endproperty
    a_code_order: assert property (p_code_order) // RQ10
        else $error("issued cycle differs from code string");

endmodule // cbs_sequencer

// ---- cbs_sequencer_tb.sv ----
`timescale 1ns/1ps

module cbs_sequencer_tb;
    import cbs_pkg::*;
    localparam int ML = 11;
    localparam int LW = $clog2(ML + 1);
    typedef struct {
        string       code;
        logic        wt;
        logic [15:0] opr;
        logic [7:0]  wd;
        logic [7:0]  vb;
    } cbs_row_t;

    logic                 i_clk_sys, i_rst, i_start, i_is_wait, i_irq;
    logic [ML-1:0][2:0]   i_code;
    logic [LW-1:0]        i_len;
    logic [15:0]          i_opr_addr, o_addr, pc, sp, opa;
    logic [7:0]           i_wdata, i_vec_base, bus_rdata, o_wdata, o_rdata;
    logic                 o_ready, o_valid, o_rw, o_rdata_valid, o_done, o_halted, o_imask;
    logic [2:0]           o_cyc_type;
    logic                 imask_e;
    logic [7:0]           exp_mem [logic [15:0]];
    int                   fails, tests_run, cycles;
    cbs_row_t             rows [7];

    cbs_sequencer #(.MAX_LEN(ML)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(i_start), .i_code(i_code),
        .i_len(i_len), .i_is_wait(i_is_wait), .i_opr_addr(i_opr_addr), .i_wdata(i_wdata),
        .i_vec_base(i_vec_base), .i_irq(i_irq), .i_bus_rdata(bus_rdata), .o_ready(o_ready),
        .o_valid(o_valid), .o_cyc_type(o_cyc_type), .o_addr(o_addr), .o_rw(o_rw),
        .o_wdata(o_wdata), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
        .o_done(o_done), .o_halted(o_halted), .o_imask(o_imask));

    cbs_mem_model mem_u (.i_clk_sys(i_clk_sys), .i_valid(o_valid), .i_addr(o_addr),
        .i_rw(o_rw), .i_wdata(o_wdata), .o_rdata(bus_rdata));

    // ----------------------------------------------------------------
    // Clock, hang guard and helpers
    // ----------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    // Whole run is under a hundred cycles; this ceiling only catches a hang
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] mem_rd(input logic [15:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : (a[7:0] ^ a[15:8] ^ 8'ha5);
    endfunction

    function automatic cbs_sym_t sym_of(input byte c);
        case (c)
            "p": return CBS_FETCH;
            "r": return CBS_RD;
            "w": return CBS_WR;
            "s": return CBS_PUSH;
            "u": return CBS_POP;
            "v": return CBS_VEC;
            default: return CBS_FREE;
        endcase
    endfunction

    // Free cycle with the byte of the previous read cycle, if any
    task automatic chk_free(input logic prd, input logic [7:0] pval);
        chk("rdata_valid", o_rdata_valid, prd);
        if (prd) chk("rdata", o_rdata, pval);
        chk("free_type", o_cyc_type, CBS_FREE);
        chk("free_rw", o_rw, 1);
    endtask

    task automatic do_reset();
        @(posedge i_clk_sys) i_rst <= 1'b1;
        #1;
        chk("rst_ready", o_ready, 1);
        chk("rst_valid", o_valid, 0);
        chk("rst_rw", o_rw, 1);
        chk("rst_imask", o_imask, 1);
        repeat (3) @(posedge i_clk_sys);
        @(posedge i_clk_sys) i_rst <= 1'b0;
        pc = 16'h0000;
        sp = 16'h00ff;
        imask_e = 1'b1;
        @(posedge i_clk_sys) #1;
        chk("valid", o_valid, 1);
    endtask

    // One instruction: accept, one free cycle, then each letter in order
    task automatic run_row(input cbs_row_t r);
        logic        prd, rdx, wr;
        logic [7:0]  pval;
        logic [15:0] a;
        cbs_sym_t    s;
        int          n, nv;
        n = r.code.len();
        @(posedge i_clk_sys);
        for (int k = 0; k < ML; k++) i_code[k] <= (k < n) ? sym_of(r.code[k]) : CBS_FREE;
        i_len <= LW'(n);
        i_is_wait <= r.wt;
        i_opr_addr <= r.opr;
        i_wdata <= r.wd;
        i_vec_base <= r.vb;
        i_start <= 1'b1;
        @(posedge i_clk_sys) i_start <= 1'b0;
        // Byte is captured at acceptance, so scramble it afterwards
        i_wdata <= ~r.wd;
        #1;
        chk_free(1'b0, 8'h00);
        opa = r.opr;
        prd = 1'b0;
        pval = 8'h00;
        nv = 0;
        for (int k = 0; k < n; k++) begin
            // A start while busy must be ignored
            @(posedge i_clk_sys) i_start <= (k == 0 && n > 1);
            #1;
            chk("rdata_valid", o_rdata_valid, prd);
            if (prd) chk("rdata", o_rdata, pval);
            s = sym_of(r.code[k]);
            rdx = 1'b0;
            wr = 1'b0;
            case (s)
                CBS_FETCH: begin a = pc; pc = pc + 16'h0001; end
                CBS_RD:    begin a = opa; opa = opa + 16'h0001; rdx = 1'b1; end
                CBS_WR:    begin a = opa; opa = opa + 16'h0001; wr = 1'b1; end
                CBS_PUSH:  begin a = sp; sp = sp - 16'h0001; wr = 1'b1; end
                CBS_POP:   begin sp = sp + 16'h0001; a = sp; rdx = 1'b1; end
                CBS_VEC:   begin a = {8'hff, r.vb[7:1], nv[0]}; rdx = 1'b1; end
                default:   a = pc;
            endcase
            chk("type", o_cyc_type, s);
            chk("rw", o_rw, !wr);
            if (s != CBS_FREE) chk("addr", o_addr, a);
            chk("wdata", o_wdata, wr ? r.wd : 8'h00);
            chk("imask", o_imask, imask_e && !(r.wt && k == n - 1));
            chk("halted", o_halted, r.wt && k == n - 1);
            if (!r.wt) chk("ready", o_ready, k == n - 1);
            if (!r.wt) chk("done", o_done, k == n - 1);
            prd = rdx;
            if (rdx) pval = mem_rd(a);
            if (s == CBS_VEC && nv == 0) pc[15:8] = pval;
            if (s == CBS_VEC && nv == 1) pc[7:0] = pval;
            if (s == CBS_VEC) nv++;
            if (wr) exp_mem[a] = r.wd;
        end
        @(posedge i_clk_sys) #1;
        chk_free(prd, pval);
        if (r.wt) begin
            chk("halted", o_halted, 1);
            chk("imask", o_imask, 0);
            repeat (3) begin
                @(posedge i_clk_sys) #1;
                chk_free(1'b0, 8'h00);
                chk("halted", o_halted, 1);
            end
            @(posedge i_clk_sys) i_irq <= 1'b1;
            #1;
            for (int j = 0; j < 6 && o_done !== 1'b1; j++) @(posedge i_clk_sys) #1;
            chk("wake_done", o_done, 1);
            chk("wake_halted", o_halted, 0);
            chk("wake_ready", o_ready, 1);
            @(posedge i_clk_sys) i_irq <= 1'b0;
            imask_e = 1'b0;
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rows = '{'{"p", 0, 16'h0010, 8'h11, 8'h00}, '{"rw", 0, 16'h1234, 8'h5a, 8'h00},
                 '{"prpp", 0, 16'h00ff, 8'h33, 8'h00},
                 '{"sssssvvfppp", 0, 16'h0000, 8'hc3, 8'hfd},
                 '{"uufp", 0, 16'h0000, 8'h00, 8'h00}, '{"wwsu", 0, 16'hffff, 8'h7e, 8'h00},
                 '{"fp", 1, 16'h0000, 8'h00, 8'h00}};
        i_rst = 1'b1;
        i_start = 1'b0;
        i_code = '0;
        i_len = '0;
        i_is_wait = 1'b0;
        i_opr_addr = 16'h0000;
        i_wdata = 8'h00;
        i_vec_base = 8'h00;
        i_irq = 1'b0;
        do_reset();
        foreach (rows[i]) run_row(rows[i]);
        // Zero-length start is ignored
        @(posedge i_clk_sys) i_len <= '0;
        i_start <= 1'b1;
        @(posedge i_clk_sys) i_start <= 1'b0;
        repeat (3) begin
            @(posedge i_clk_sys) #1;
            chk("len0_ready", o_ready, 1);
            chk_free(1'b0, 8'h00);
        end
        // Reset on the last cycle of a four-cycle instruction, then restart cleanly
        @(posedge i_clk_sys) i_len <= LW'(4);
        i_start <= 1'b1;
        @(posedge i_clk_sys) i_start <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        do_reset();
        run_row('{"psu", 0, 16'h0000, 8'h9c, 8'h00});
        give_verdict();
    end
endmodule // cbs_sequencer_tb
